// File: hdl/sdl_pkg.sv
// constants shared by the serial dac input latch and its pin synchroniser
// assumes a single 125 mhz system clock with a synchronous active-high reset
package sdl_pkg;
  localparam int SDL_WORD_W = 12;           // serial word and dac code width
  localparam int SDL_PIN_W = 3;             // synchronised pins in one bundle
  localparam int SDL_PIN_SCLK = 0;          // bundle position of serial clock
  localparam int SDL_PIN_DATA = 1;          // bundle position of serial data
  localparam int SDL_PIN_LOAD = 2;          // bundle position of load strobe
  // idle pin levels: clock low, data low, load strobe inactive (high)
  localparam logic [SDL_PIN_W-1:0] SDL_PIN_IDLE = 3'h4;
  localparam logic [SDL_WORD_W-1:0] SDL_CODE_RST = 12'h000;
  localparam logic SDL_SCLK_RST = 1'b0;
  localparam logic SDL_VALID_RST = 1'b0;
endpackage : sdl_pkg

// File: hdl/sdl_pins_if.sv
// synchronised pin levels passed from the synchroniser to the latch core
// assumes both ends run on the same system clock
interface sdl_pins_if;
  logic serial_clk_s;
  logic serial_data_s;
  logic load_strobe_n_s;
  modport sync_side (
    output serial_clk_s,
    output serial_data_s,
    output load_strobe_n_s
  );
  modport core_side (
    input serial_clk_s,
    input serial_data_s,
    input load_strobe_n_s
  );
endinterface : sdl_pins_if

// File: hdl/sdl_sync.sv
// two-flop synchroniser for the three host pins
// assumes the pins are asynchronous to clock; only stage two is exported
module sdl_sync (
  input wire logic clock,
  input wire logic rst,
  input wire logic serial_clk,
  input wire logic serial_data_in,
  input wire logic load_strobe_n,
  sdl_pins_if.sync_side pins
);
  import sdl_pkg::*;

  logic [SDL_PIN_W-1:0] meta_ff;
  logic [SDL_PIN_W-1:0] sync_ff;
  logic [SDL_PIN_W-1:0] raw_pins;

  // all three pins sampled together so clock and data keep their alignment
  assign raw_pins = {load_strobe_n, serial_data_in, serial_clk};

  // first stage feeds only the second stage
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_ff <= SDL_PIN_IDLE;
      sync_ff <= SDL_PIN_IDLE;
    end else begin
      meta_ff <= raw_pins;
      sync_ff <= meta_ff;
    end
  end

  assign pins.serial_clk_s = sync_ff[SDL_PIN_SCLK];
  assign pins.serial_data_s = sync_ff[SDL_PIN_DATA];
  assign pins.load_strobe_n_s = sync_ff[SDL_PIN_LOAD];
endmodule // sdl_sync

// File: hdl/sdl_top.sv
// serial dac input latch: 12-bit shift register plus level-loaded dac register
// assumes the host drives serial clock, data and load strobe asynchronously;
// the serial clock is oversampled, so it must stay well below clock / 4
// every pin passes the two-flop synchroniser, so a pin change takes effect
// about three clocks later; the host must hold each level longer than that
// rst stands in for power-up: the contents it leaves are zero, not a code
//
// Summary of operation
// - a serial clock rise with strobe high shifts one bit; the dac holds.
// - with strobe low the dac follows the shift word, which stays still.
// - the strobe acts on level; its rise with clock low holds all 12 bits.
// - the 12-bit word comes msb first and each bit enters at the bottom.
// - surplus bits fall off the top so only the last twelve are loaded.
module sdl_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic serial_clk,
  input wire logic serial_data_in,
  input wire logic load_strobe_n,
  output logic [sdl_pkg::SDL_WORD_W-1:0] dac_code,
  output logic code_valid
);
  import sdl_pkg::*;

  // run-length helper widths: counts 0 to the word width inclusive
  localparam int SDL_RUN_W = $clog2(SDL_WORD_W + 1);
  localparam logic [SDL_RUN_W-1:0] SDL_RUN_ZERO = SDL_RUN_W'(0);
  localparam logic [SDL_RUN_W-1:0] SDL_RUN_ONE = SDL_RUN_W'(1);
  localparam logic [SDL_RUN_W-1:0] SDL_RUN_LAST = SDL_RUN_W'(SDL_WORD_W - 1);
  localparam logic [SDL_RUN_W-1:0] SDL_RUN_FULL = SDL_RUN_W'(SDL_WORD_W);

  // synchronised pin levels travel from the synchroniser in one bundle
  sdl_pins_if pins ();

  // edge finder, shift word, dac word, valid flag and check helpers
  logic sclk_d_ff;
  logic sclk_rise;
  logic load_active;
  logic [SDL_WORD_W-1:0] shift_ff;
  logic [SDL_WORD_W-1:0] nxt_shift;
  logic [SDL_WORD_W-1:0] dac_ff;
  logic valid_ff;
  logic [SDL_RUN_W-1:0] run_len_ff;
  logic first_bit_ff;

  // no logic here reads a raw pin; metastability stays in the synchroniser
  sdl_sync u_sync (
    .clock(clock),
    .rst(rst),
    .serial_clk(serial_clk),
    .serial_data_in(serial_data_in),
    .load_strobe_n(load_strobe_n),
    .pins(pins)
  );

  // edge finder looks at synchronised clock only, never the first stage
  // its reset level matches the idle clock, so reset never fakes a rise
  always_ff @(posedge clock) begin
    if (rst) begin
      sclk_d_ff <= SDL_SCLK_RST;
    end else begin
      sclk_d_ff <= pins.serial_clk_s;
    end
  end

  // one-cycle pulse per host clock rise; the strobe is a plain level
  assign sclk_rise = pins.serial_clk_s & ~sclk_d_ff;
  assign load_active = ~pins.load_strobe_n_s;

  // new bit at the bottom; the oldest bit drops off the top
  assign nxt_shift = {shift_ff[SDL_WORD_W-2:0], pins.serial_data_s};

  // shift register: advances only on a clock edge while not loading
  // a rise that meets a low strobe is dropped, not held for later
  always_ff @(posedge clock) begin
    if (rst) begin
      shift_ff <= SDL_CODE_RST;
    end else if (sclk_rise && !load_active) begin
      shift_ff <= nxt_shift;
    end
  end

  // dac register: transparent while the strobe is low, latched otherwise;
  // a rising strobe simply stops the copy, so the last word stays held
  always_ff @(posedge clock) begin
    if (rst) begin
      dac_ff <= SDL_CODE_RST;
    end else if (load_active) begin
      dac_ff <= shift_ff;
    end
  end

  // contents are zero-filled by reset but only meaningful after a load
  // a user may ignore dac_code until the flag is up
  always_ff @(posedge clock) begin
    if (rst) begin
      valid_ff <= SDL_VALID_RST;
    end else if (load_active) begin
      valid_ff <= 1'b1;
    end
  end

  // helper for the msb-first check: host clock rises shifted since the
  // last load, saturating at the word width so a long run cannot wrap
  always_ff @(posedge clock) begin
    if (rst || load_active) begin
      run_len_ff <= SDL_RUN_ZERO;
    end else if (sclk_rise && run_len_ff != SDL_RUN_FULL) begin
      run_len_ff <= run_len_ff + SDL_RUN_ONE;
    end
  end

  // helper: the first bit of the current run, the one that must end on top
  always_ff @(posedge clock) begin
    if (rst) begin
      first_bit_ff <= SDL_PIN_IDLE[SDL_PIN_DATA];
    end else if (sclk_rise && !load_active && run_len_ff == SDL_RUN_ZERO) begin
      first_bit_ff <= pins.serial_data_s;
    end
  end

  // outputs come straight from their registers
  assign dac_code = dac_ff;
  assign code_valid = valid_ff;

  // the checks run on synchronised levels, two cycles after the pins move;
  // all but reset_quiet_a are off during reset, when every register is forced

  // a shifting edge leaves the dac word untouched
  shift_hold_a: assert property (
    @(posedge clock) disable iff (rst)
    sclk_rise && !load_active |=> $stable(dac_ff))
    else $error("dac word changed during a shift");

  // while loading the dac follows the shift word and shifting stops
  load_follow_a: assert property (
    @(posedge clock) disable iff (rst)
    load_active |=> dac_ff == $past(shift_ff) && $stable(shift_ff))
    else $error("dac word did not follow shift word while loading");

  // when the strobe rises with the clock low, all bits are already held
  strobe_rise_a: assert property (
    @(posedge clock) disable iff (rst)
    $fell(load_active) && !pins.serial_clk_s |->
      dac_ff == shift_ff ##1 $stable(dac_ff))
    else $error("dac word not latched at strobe release");

  // the sampled bit enters at the bottom of the word
  bit_entry_a: assert property (
    @(posedge clock) disable iff (rst)
    sclk_rise && !load_active |=> shift_ff[0] == $past(pins.serial_data_s))
    else $error("serial bit did not enter at the bottom");

  // the bit below the top moves up into it, the old top one is lost
  bit_move_a: assert property (
    @(posedge clock) disable iff (rst)
    sclk_rise && !load_active |=>
      shift_ff[SDL_WORD_W-1] == $past(shift_ff[SDL_WORD_W-2]))
    else $error("shift word did not move up by one");

  // no shift without a clock edge
  idle_still_a: assert property (
    @(posedge clock) disable iff (rst)
    !sclk_rise |=> $stable(shift_ff))
    else $error("shift word moved without a clock edge");

  // the valid flag rises exactly one cycle after the first load
  first_load_a: assert property (
    @(posedge clock) disable iff (rst)
    !valid_ff |=> valid_ff == $past(load_active))
    else $error("code valid flag wrong after first load");

  // the dac word stays latched whenever the strobe is seen high
  dac_latch_a: assert property (
    @(posedge clock) disable iff (rst)
    !load_active |=> $stable(dac_ff))
    else $error("dac word moved with the strobe high");

  // one cycle into a load the dac word already equals the shift word
  load_transp_a: assert property (
    @(posedge clock) disable iff (rst)
    $past(load_active) |-> dac_ff == shift_ff)
    else $error("dac word not transparent during a load");

  // the dac word never changes unless a load was seen
  dac_cause_a: assert property (
    @(posedge clock) disable iff (rst)
    $changed(dac_ff) |-> $past(load_active))
    else $error("dac word changed without a load");

  // the shift word never changes without a rise outside a load
  shift_cause_a: assert property (
    @(posedge clock) disable iff (rst)
    $changed(shift_ff) |-> $past(sclk_rise) && !$past(load_active))
    else $error("shift word changed without a clock rise");

  // one pin edge is one pulse, so one host clock is one bit
  rise_single_a: assert property (
    @(posedge clock) disable iff (rst)
    sclk_rise |=> !sclk_rise)
    else $error("serial clock rise reported twice in a row");

  // once the strobe is released the copy stops at once
  strobe_stop_a: assert property (
    @(posedge clock) disable iff (rst)
    $fell(load_active) |=> $stable(dac_ff))
    else $error("dac word moved after strobe release");

  // the valid flag only leaves by reset
  valid_sticky_a: assert property (
    @(posedge clock) disable iff (rst)
    valid_ff |=> valid_ff)
    else $error("code valid flag dropped without reset");

  // any load raises the valid flag
  valid_set_a: assert property (
    @(posedge clock) disable iff (rst)
    load_active |=> valid_ff)
    else $error("code valid flag not set by a load");

  // synchroniser and edge finder leave reset idle: no false bit or load
  reset_quiet_a: assert property (
    @(posedge clock)
    $fell(rst) |-> !sclk_rise && !load_active)
    else $error("false clock rise or load right after reset");

  // each older bit climbs one place per shift; the top one is lost
  for (genvar b = 1; b < SDL_WORD_W; b++) begin : g_bit_climb
    bit_climb_a: assert property (
      @(posedge clock) disable iff (rst)
      sclk_rise && !load_active |=> shift_ff[b] == $past(shift_ff[b-1]))
      else $error("shift word bit did not climb one place");
  end

  // the twelfth shift of a run puts its first bit on top: msb first
  msb_first_a: assert property (
    @(posedge clock) disable iff (rst)
    sclk_rise && !load_active && run_len_ff == SDL_RUN_LAST |=>
      shift_ff[SDL_WORD_W-1] == first_bit_ff)
    else $error("first bit of a word did not reach the top");
endmodule // sdl_top

// File: verification/sdl_host_model.sv
// host model driving serial clock, serial data and the load strobe
// assumes it is stepped on falling edges of the 125 mhz system clock
module sdl_host_model (
  input wire logic clock,
  output logic serial_clk,
  output logic serial_data_in,
  output logic load_strobe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // serial clock stands low between frames, strobe idles high
  initial begin
    serial_clk = 1'b0;
    serial_data_in = 1'b0;
    load_strobe_n = 1'b1;
  end
  // n bits msb first; 10 clocks per half period gives a 160 ns link clock
  task automatic send(input logic [23:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      serial_data_in = bits[i];
      repeat (10) @(negedge clock);
      serial_clk = 1'b1;
      repeat (10) @(negedge clock);
      serial_clk = 1'b0;
    end
    // data leaves the last bit once, so a late sample cannot pass as good
    serial_data_in = ~bits[0];
  endtask
  // strobe pulse, released with serial clock low
  task automatic load(input int low_cycles);
    load_strobe_n = 1'b0;
    repeat (low_cycles) @(negedge clock);
    load_strobe_n = 1'b1;
  endtask
endmodule // sdl_host_model

// File: verification/testbench.sv
// self-checking bench for the serial dac input latch
// assumes sdl_pkg and the design files are compiled first
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sdl_pkg::*;
  logic clock, rst, serial_clk, serial_data_in, load_strobe_n, code_valid;
  logic [SDL_WORD_W-1:0] dac_code;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;
  sdl_top sdl_top_i (.clock(clock), .rst(rst), .serial_clk(serial_clk),
    .serial_data_in(serial_data_in), .load_strobe_n(load_strobe_n),
    .dac_code(dac_code), .code_valid(code_valid));
  sdl_host_model sdl_host_model_i (.clock(clock), .serial_clk(serial_clk),
    .serial_data_in(serial_data_in), .load_strobe_n(load_strobe_n));
  // 8 ns system clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // hang guard, well above the roughly 1170 cycles the tests need
  always @(posedge clock) begin
    cycles++;
    if (cycles == 6000) begin
      n_mismatch++;
      $display("mismatch cycle_limit expected 0 seen %0d", cycles);
      end_of_test();
    end
  end
  task automatic chk(input string what, input logic [11:0] exp,
                     input logic [11:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task end_of_test;
    if (n_mismatch == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic t_reset;
    chk("dac_code", 12'h000, dac_code);
    chk("code_valid", 12'h000, {11'h000, code_valid});
  endtask
  task automatic t_load_word;
    sdl_host_model_i.send(24'h000a5c, 12);
    sdl_host_model_i.load(4);
    repeat (4) @(negedge clock);
    chk("dac_code", 12'ha5c, dac_code);
    chk("code_valid", 12'h001, {11'h000, code_valid});
  endtask
  // a full word shifted with strobe high must not reach the dac register
  task automatic t_shift_holds;
    sdl_host_model_i.send(24'h0003c1, 12);
    repeat (6) @(negedge clock);
    chk("dac_code", 12'ha5c, dac_code);
    sdl_host_model_i.load(2);
    repeat (4) @(negedge clock);
    chk("dac_code", 12'h3c1, dac_code);
  endtask
  task automatic t_surplus;
    sdl_host_model_i.send(24'h00b123, 16);
    sdl_host_model_i.load(3);
    repeat (4) @(negedge clock);
    chk("dac_code", 12'h123, dac_code);
  endtask
  // a serial clock edge during a long low strobe must be ignored
  task automatic t_strobe_low;
    fork
      sdl_host_model_i.load(70);
      begin
        repeat (5) @(negedge clock);
        sdl_host_model_i.send(24'h000001, 1);
        repeat (4) @(negedge clock);
        chk("dac_code", 12'h123, dac_code);
      end
    join
    repeat (4) @(negedge clock);
    chk("dac_code", 12'h123, dac_code);
  endtask
  // a reset in mid-run clears both outputs, then a word loads again
  task automatic t_mid_reset;
    rst = 1'b1;
    repeat (8) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    t_reset();
    t_load_word();
  endtask
  // main sequence, inputs driven on falling edges
  initial begin
    rst = 1'b1;
    repeat (8) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    t_reset();
    t_load_word();
    t_shift_holds();
    t_surplus();
    t_strobe_low();
    t_mid_reset();
    end_of_test();
  end
endmodule // testbench
